// ### hdl/serial_port_map.svh
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH
// Arbitrary value, not a real part's address
`define CHIP_ADDR_DEFAULT   7'h2a
`define SUBADDR_WRITE_MAX   8'h0f
`define SUBADDR_READ_STATUS 8'h80
`define SUBADDR_READ_ADC    8'h81
`define BYTE_BITS           4'h8
`define ACK_SLOT            4'h8
`define LINK_DIV_HALF       8'h04
// Link slots per frame, closing slot included
`define SLOTS_2W_ONE        7'h1c
`define SLOTS_2W_TWO        7'h25
`define SLOTS_2W_READ       7'h26
`define SLOTS_3W_ONE        7'h11
`define SLOTS_3W_TWO        7'h19
`endif

// ### hdl/serial_port_pkg.sv
package serial_port_pkg;
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_CHIP,
    PH_SUB,
    PH_DATA
  } phase_type;
  typedef enum logic [1:0] {
    M_IDLE,
    M_RUN,
    M_DONE
  } master_state_type;
endpackage

// ### hdl/serial_port_if.sv
`timescale 1ns/1ps
interface serial_port_if;
  logic bus_format_select;
  logic enable_n;
  logic serial_clock_line;
  logic sdl_dev_out;
  logic sdl_dev_oe;
  logic sdl_host_out;
  logic sdl_host_oe;
  logic serial_data_line;
  // Open-drain in two-wire mode, driven in three-wire mode; idle high
  assign serial_data_line = (sdl_dev_oe ? sdl_dev_out : 1'b1) & (sdl_host_oe ? sdl_host_out : 1'b1);
  modport device (
    input  bus_format_select,
    input  enable_n,
    input  serial_clock_line,
    input  serial_data_line,
    output sdl_dev_out,
    output sdl_dev_oe
  );
  modport host (
    output bus_format_select,
    output enable_n,
    output serial_clock_line,
    output sdl_host_out,
    output sdl_host_oe,
    input  serial_data_line
  );
endinterface

// ### hdl/serial_port_device.sv
`timescale 1ns/1ps
`include "serial_port_map.svh"
module serial_port_device #(
  parameter logic [6:0] CHIP_ADDR = `CHIP_ADDR_DEFAULT  // Arbitrary value
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Link
  serial_port_if.device   link,
  // Register bank side
  output logic            wr_strobe,
  output logic [7:0]      wr_subaddr,
  output logic [7:0]      wr_data,
  output logic            wr_high_byte,
  input  wire logic [7:0] status_value,
  input  wire logic [7:0] adc_value,
  output logic            busy
);
  if (CHIP_ADDR == 7'h00) begin : g_bad_addr
    $error("chip address must be nonzero");
  end

  logic [1:0] scl_s_q, sda_s_q, en_s_q, fmt_s_q;
  logic       scl_p_q, sda_p_q, en_p_q;
  serial_port_pkg::phase_type phase_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] sub_q;
  logic       rd_q, ack_drv_q, tx_q, byte_n_q, sent_q;
  logic [7:0] tx_byte_q;
  logic       rise, fall, start_c, stop_c, three_w, en_act, abort;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      en_s_q  <= 2'h3;
      fmt_s_q <= 2'h0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      en_p_q  <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], link.serial_clock_line};
      sda_s_q <= {sda_s_q[0], link.serial_data_line};
      en_s_q  <= {en_s_q[0], link.enable_n};
      fmt_s_q <= {fmt_s_q[0], link.bus_format_select};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
      en_p_q  <= en_s_q[1];
    end
  end

  assign three_w = fmt_s_q[1];
  assign rise    = scl_s_q[1] & ~scl_p_q;
  assign fall    = ~scl_s_q[1] & scl_p_q;
  assign start_c = ~three_w & scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
  assign stop_c  = ~three_w & scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];
  assign en_act  = three_w & ~en_s_q[1];
  assign abort   = three_w ? ~en_act : stop_c;
  assign busy    = phase_q != serial_port_pkg::PH_IDLE;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      phase_q      <= serial_port_pkg::PH_IDLE;
      bit_q        <= 4'h0;
      shift_q      <= 8'h00;
      sub_q        <= 8'h00;
      rd_q         <= 1'b0;
      sent_q       <= 1'b0;
      byte_n_q     <= 1'b0;
      wr_strobe    <= 1'b0;
      wr_subaddr   <= 8'h00;
      wr_data      <= 8'h00;
      wr_high_byte <= 1'b0;
    end else begin
      wr_strobe <= 1'b0;
      if (abort) begin
        phase_q <= serial_port_pkg::PH_IDLE;
        rd_q    <= 1'b0;
        sent_q  <= 1'b0;
      end else if (start_c) begin
        phase_q <= serial_port_pkg::PH_CHIP;
        bit_q   <= 4'h0;
        sent_q  <= 1'b0;
      end else if (three_w && en_act && en_p_q) begin
        phase_q  <= serial_port_pkg::PH_SUB;
        bit_q    <= 4'h0;
        rd_q     <= 1'b0;
      end else if (rise && phase_q != serial_port_pkg::PH_IDLE) begin
        if (!three_w && bit_q == `ACK_SLOT) begin
          bit_q  <= 4'h0;
          sent_q <= 1'b0;
          // no ack after a sent byte ends read
          if (sent_q && sda_s_q[1]) begin
            phase_q <= serial_port_pkg::PH_IDLE;
          end
        end else begin
          shift_q <= {shift_q[6:0], sda_s_q[1]};
          bit_q   <= bit_q + 4'h1;
          if (bit_q == `BYTE_BITS - 4'h1) begin
            if (three_w) begin
              bit_q <= 4'h0;
            end
            case (phase_q)
              serial_port_pkg::PH_CHIP: begin
                rd_q    <= sda_s_q[1];
                phase_q <= (shift_q[6:0] == CHIP_ADDR)
                           ? (sda_s_q[1] ? serial_port_pkg::PH_DATA : serial_port_pkg::PH_SUB)
                           : serial_port_pkg::PH_IDLE;
              end
              serial_port_pkg::PH_SUB: begin
                sub_q    <= {shift_q[6:0], sda_s_q[1]};
                byte_n_q <= 1'b0;
                rd_q     <= three_w & shift_q[6];
                phase_q  <= serial_port_pkg::PH_DATA;
              end
              serial_port_pkg::PH_DATA: begin
                // Device was transmitter for this byte
                sent_q <= rd_q;
                if (!rd_q && sub_q <= `SUBADDR_WRITE_MAX) begin
                  wr_strobe    <= 1'b1;
                  wr_subaddr   <= sub_q;
                  wr_data      <= {shift_q[6:0], sda_s_q[1]};
                  wr_high_byte <= ~byte_n_q;
                  byte_n_q     <= ~byte_n_q;
                end
              end
              default: phase_q <= serial_port_pkg::PH_IDLE;
            endcase
          end
        end
      end
    end
  end

  // Output side, updated after falling edge
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ack_drv_q <= 1'b0;
      tx_q      <= 1'b0;
      tx_byte_q <= 8'h00;
    end else if (abort || start_c || !busy) begin
      ack_drv_q <= 1'b0;
      tx_q      <= 1'b0;
    end else if (fall) begin
      ack_drv_q <= 1'b0;
      tx_q      <= 1'b0;
      if (!three_w && bit_q == `ACK_SLOT && !sent_q) begin
        ack_drv_q <= 1'b1;
      end else if (rd_q && phase_q == serial_port_pkg::PH_DATA && bit_q < `BYTE_BITS) begin
        tx_q <= 1'b1;
        if (bit_q == 4'h0) begin
          tx_byte_q <= (sub_q == `SUBADDR_READ_ADC) ? adc_value : status_value;
        end
      end
    end
  end

  logic [7:0] rd_src;
  assign rd_src = (bit_q == 4'h0) ? ((sub_q == `SUBADDR_READ_ADC) ? adc_value : status_value) : tx_byte_q;
  logic       tx_bit_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tx_bit_q <= 1'b1;
    end else if (fall) begin
      tx_bit_q <= rd_src[3'h7 - bit_q[2:0]];
    end
  end

  assign link.sdl_dev_oe  = ack_drv_q | (tx_q & (three_w | ~tx_bit_q));
  assign link.sdl_dev_out = ack_drv_q ? 1'b0 : tx_bit_q;
  // the link is fully served by sys_clk sampling
endmodule

// ### hdl/serial_port_host.sv
`timescale 1ns/1ps
`include "serial_port_map.svh"
module serial_port_host #(
  parameter logic [6:0] CHIP_ADDR = `CHIP_ADDR_DEFAULT  // Arbitrary value
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Link
  serial_port_if.host     link,
  // User request
  input  wire logic       three_wire,
  input  wire logic       req,
  input  wire logic       req_read,
  input  wire logic [7:0] req_subaddr,
  input  wire logic [15:0] req_data,
  input  wire logic       req_two_bytes,
  output logic            req_ready,
  output logic            done,
  output logic [7:0]      rd_data,
  output logic            ack_error
);
  serial_port_pkg::master_state_type st_q;
  logic [7:0]  div_q;
  logic [1:0]  ph_q;
  logic [6:0]  slot_q, n_slots_q, n_d;
  logic [63:0] drv_q, smp_q, rs_q, ack_q;
  logic [63:0] drv_d, smp_d, rs_d, ack_d;
  logic [1:0]  sda_s_q;
  logic        last_slot;

  // Frame builder: one bit per link slot, first slot at bit 63
  always_comb begin
    smp_d = 64'h0;
    rs_d  = 64'h0;
    ack_d = 64'h0;
    if (three_wire) begin
      if (req_read) begin
        drv_d = {req_subaddr, 8'hff, 48'hffff_ffff_ffff};
        smp_d = {8'h00, 8'hff, 48'h0};
        n_d   = `SLOTS_3W_ONE;
      end else if (req_two_bytes) begin
        drv_d = {req_subaddr, req_data, 40'hff_ffff_ffff};
        n_d   = `SLOTS_3W_TWO;
      end else begin
        drv_d = {req_subaddr, req_data[7:0], 48'hffff_ffff_ffff};
        n_d   = `SLOTS_3W_ONE;
      end
    end else if (req_read) begin
      // restart, read address, data, no acknowledge
      drv_d = {CHIP_ADDR, 1'b0, 1'b1, req_subaddr, 1'b1, 1'b1, CHIP_ADDR, 1'b1, 1'b1, 8'hff, 1'b1, 27'h7ff_ffff};
      smp_d = {28'h0, 8'hff, 28'h0};
      rs_d  = {18'h0, 1'b1, 45'h0};
      ack_d = {8'h0, 1'b1, 8'h0, 1'b1, 1'b0, 8'h0, 1'b1, 36'h0};
      n_d   = `SLOTS_2W_READ;
    end else if (req_two_bytes) begin
      drv_d = {CHIP_ADDR, 1'b0, 1'b1, req_subaddr, 1'b1, req_data[15:8], 1'b1, req_data[7:0], 1'b1, 28'hfff_ffff};
      ack_d = {8'h0, 1'b1, 8'h0, 1'b1, 8'h0, 1'b1, 8'h0, 1'b1, 28'h0};
      n_d   = `SLOTS_2W_TWO;
    end else begin
      drv_d = {CHIP_ADDR, 1'b0, 1'b1, req_subaddr, 1'b1, req_data[7:0], 1'b1, 37'h1f_ffff_ffff};
      ack_d = {8'h0, 1'b1, 8'h0, 1'b1, 8'h0, 1'b1, 37'h0};
      n_d   = `SLOTS_2W_ONE;
    end
  end

  assign last_slot = slot_q == n_slots_q - 7'h01;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) sda_s_q <= 2'h3;
    else sda_s_q <= {sda_s_q[0], link.serial_data_line};
  end

  assign req_ready = st_q == serial_port_pkg::M_IDLE;
  assign link.bus_format_select = three_wire;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_q <= serial_port_pkg::M_IDLE;
      div_q <= 8'h00;
      ph_q <= 2'h0;
      slot_q <= 7'h00;
      link.enable_n <= 1'b1;
      link.serial_clock_line <= 1'b1;
      link.sdl_host_out <= 1'b1;
      link.sdl_host_oe <= 1'b0;
      done <= 1'b0;
      rd_data <= 8'h00;
      ack_error <= 1'b0;
      drv_q <= 64'h0;
      smp_q <= 64'h0;
      rs_q <= 64'h0;
      ack_q <= 64'h0;
      n_slots_q <= 7'h00;
    end else begin
      done <= 1'b0;
      case (st_q)
        serial_port_pkg::M_IDLE: if (req) begin
          drv_q <= drv_d;
          smp_q <= smp_d;
          rs_q <= rs_d;
          ack_q <= ack_d;
          n_slots_q <= n_d;
          slot_q <= 7'h00;
          div_q <= 8'h00;
          ph_q <= 2'h0;
          ack_error <= 1'b0;
          st_q <= serial_port_pkg::M_RUN;
          link.enable_n <= ~three_wire;
          link.sdl_host_oe <= ~three_wire;
          link.sdl_host_out <= 1'b0;
        end
        serial_port_pkg::M_RUN: begin
          div_q <= div_q + 8'h01;
          if (div_q == `LINK_DIV_HALF - 8'h01) begin
            div_q <= 8'h00;
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h0) begin
              link.serial_clock_line <= 1'b0;
              // Release before the device starts to drive
              if (smp_q[63]) link.sdl_host_oe <= 1'b0;
            end else if (ph_q == 2'h1) begin
              if (last_slot) begin
                // stop needs data low; three-wire ends on enable
                link.sdl_host_oe <= ~three_wire;
                link.sdl_host_out <= 1'b0;
                link.enable_n <= 1'b1;
              end else if (rs_q[63]) begin
                link.sdl_host_oe <= 1'b0;
              end else begin
                link.sdl_host_oe <= three_wire ? ~smp_q[63] : ~drv_q[63];
                link.sdl_host_out <= drv_q[63];
              end
            end else if (ph_q == 2'h2) begin
              link.serial_clock_line <= 1'b1;
            end else begin
              if (last_slot) begin
                link.sdl_host_oe <= 1'b0;
                st_q <= serial_port_pkg::M_DONE;
              end else if (rs_q[63]) begin
                link.sdl_host_oe <= 1'b1;
                link.sdl_host_out <= 1'b0;
              end
              if (smp_q[63]) rd_data <= {rd_data[6:0], sda_s_q[1]};
              if (ack_q[63] && sda_s_q[1]) ack_error <= 1'b1;
              drv_q <= {drv_q[62:0], 1'b1};
              smp_q <= {smp_q[62:0], 1'b0};
              rs_q <= {rs_q[62:0], 1'b0};
              ack_q <= {ack_q[62:0], 1'b0};
              slot_q <= slot_q + 7'h01;
            end
          end
        end
        serial_port_pkg::M_DONE: begin
          // close with stop or enable high
          link.serial_clock_line <= 1'b1;
          link.sdl_host_oe <= 1'b0;
          link.enable_n <= 1'b1;
          done <= 1'b1;
          st_q <= serial_port_pkg::M_IDLE;
        end
        default: st_q <= serial_port_pkg::M_IDLE;
      endcase
    end
  end
endmodule

// ### verification/serial_port_monitor.sv
`timescale 1ns/1ps
module serial_port_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Link
  input wire logic bus_format_select,
  input wire logic enable_n,
  input wire logic serial_clock_line,
  input wire logic serial_data_line,
  input wire logic sdl_dev_out,
  input wire logic sdl_dev_oe,
  input wire logic sdl_host_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_idle_off;
    bus_format_select && enable_n && $past(enable_n, 3) |-> !sdl_dev_oe;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("device drives while disabled");
  property p_tw_stable;
    bus_format_select && !enable_n && serial_clock_line && $past(serial_clock_line) |-> $stable(serial_data_line);
  endproperty
  a_tw_stable: assert property (p_tw_stable) else $error("data moved while clock high");
  property p_oe_clk_low;
    $changed(sdl_dev_oe) |-> !serial_clock_line;
  endproperty
  a_oe_clk_low: assert property (p_oe_clk_low) else $error("drive switched while clock high");
  property p_out_clk_low;
    sdl_dev_oe && $changed(sdl_dev_out) |-> !serial_clock_line;
  endproperty
  a_out_clk_low: assert property (p_out_clk_low) else $error("output bit moved while clock high");
  property p_open_drain;
    !bus_format_select && sdl_dev_oe |-> !sdl_dev_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("two-wire drive not low");
  property p_stop_idle;
    !bus_format_select && serial_clock_line && $past(serial_clock_line) && $rose(serial_data_line)
      |-> ##1 !sdl_dev_oe [*2];
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("device active after stop");
  property p_start_quiet;
    !bus_format_select && serial_clock_line && $past(serial_clock_line) && $fell(serial_data_line)
      |-> ##1 !sdl_dev_oe [*4];
  endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("device drives during address");
  property p_sub_quiet;
    bus_format_select && $fell(enable_n) |-> !sdl_dev_oe [*8];
  endproperty
  a_sub_quiet: assert property (p_sub_quiet) else $error("device drives during sub-address");
  property p_no_clash;
    bus_format_select && sdl_dev_oe |-> !sdl_host_oe;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
  c_tw_frame: cover property (bus_format_select && $fell(enable_n));
  c_tw_read: cover property (bus_format_select && $rose(sdl_dev_oe));
  c_i2c_stop: cover property (!bus_format_select && serial_clock_line && $rose(serial_data_line));
  c_i2c_ack: cover property (!bus_format_select && $rose(sdl_dev_oe));
endmodule

// ### verification/tb_dual_mode_serial_reg_port.sv
`timescale 1ns/1ps
module tb_dual_mode_serial_reg_port;
  logic        sys_clk, reset_n, three_wire, req, req_read, req_two_bytes;
  logic [7:0]  req_subaddr, status_value, adc_value, wr_subaddr, wr_data, rd_data;
  logic [15:0] req_data;
  logic        wr_strobe, wr_high_byte, busy, req_ready, done, ack_error;
  logic [16:0] wq[$];
  logic [7:0]  wsub[12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0d, 8'h0e, 8'h0f};
  int          n_fail, comparisons, cycles;
  serial_port_if link_if ();
  serial_port_device u_serial_port_device (.sys_clk(sys_clk), .reset_n(reset_n), .link(link_if.device),
    .wr_strobe(wr_strobe), .wr_subaddr(wr_subaddr), .wr_data(wr_data), .wr_high_byte(wr_high_byte),
    .status_value(status_value), .adc_value(adc_value), .busy(busy));
  serial_port_host u_serial_port_host (.sys_clk(sys_clk), .reset_n(reset_n), .link(link_if.host),
    .three_wire(three_wire), .req(req), .req_read(req_read), .req_subaddr(req_subaddr), .req_data(req_data),
    .req_two_bytes(req_two_bytes), .req_ready(req_ready), .done(done), .rd_data(rd_data), .ack_error(ack_error));
  serial_port_monitor u_serial_port_monitor (.sys_clk(sys_clk), .reset_n(reset_n),
    .bus_format_select(link_if.bus_format_select), .enable_n(link_if.enable_n),
    .serial_clock_line(link_if.serial_clock_line), .serial_data_line(link_if.serial_data_line),
    .sdl_dev_out(link_if.sdl_dev_out), .sdl_dev_oe(link_if.sdl_dev_oe), .sdl_host_oe(link_if.sdl_host_oe));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("mismatches=%0d comparisons=%0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Single-byte registers
  function automatic logic exp_two(input logic [7:0] s);
    return !(s inside {8'h03, 8'h08, 8'h0d, 8'h0e});
  endfunction
  function automatic logic [7:0] exp_rd(input logic [7:0] s);
    return (s == 8'h80) ? status_value : adc_value;
  endfunction
  always @(posedge sys_clk) begin
    if (wr_strobe === 1'b1)
      wq.push_back({wr_high_byte, wr_subaddr, wr_data});
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_fail++;
      end_of_test();
    end
  end
  task do_op(input logic tw, input logic rd, input logic [7:0] sub, input logic [15:0] d);
    int k;
    @(posedge sys_clk);
    three_wire <= tw;
    req_read <= rd;
    req_subaddr <= sub;
    req_data <= d;
    req_two_bytes <= exp_two(sub);
    status_value <= 8'($urandom());
    adc_value <= 8'($urandom());
    @(posedge sys_clk);
    wq.delete();
    req <= 1'b1;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (req_ready !== 1'b1 && k < 2000);
    @(posedge sys_clk);
    req <= 1'b0;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (done !== 1'b1 && k < 4000);
    check({23'h0, done}, 24'h1);
    repeat (2) @(negedge sys_clk);
    check({23'h0, ack_error}, 24'h0);
    check({23'h0, busy}, 24'h0);
    if (rd) begin
      check({16'h0, rd_data}, {16'h0, exp_rd(sub)});
    end else begin
      check(24'(wq.size()), exp_two(sub) ? 24'h2 : 24'h1);
      if (wq.size() > 0)
        check({7'h0, wq[0]}, {7'h0, 1'b1, sub, exp_two(sub) ? d[15:8] : d[7:0]});
      if (wq.size() > 1)
        check({7'h0, wq[1]}, {7'h0, 1'b0, sub, d[7:0]});
    end
  endtask
  initial begin
    reset_n = 1'b0;
    three_wire = 1'b0;
    req = 1'b0;
    req_read = 1'b0;
    req_two_bytes = 1'b0;
    req_subaddr = 8'h00;
    req_data = 16'h0000;
    status_value = 8'h00;
    adc_value = 8'h00;
    void'($urandom(26678));
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int tw = 0; tw < 2; tw++) begin
      // Boundary sub-addresses, both widths, both read places
      do_op(tw[0], 1'b0, 8'h00, 16'ha55a);
      do_op(tw[0], 1'b0, 8'h0f, 16'h8001);
      do_op(tw[0], 1'b0, 8'h03, 16'h00ff);
      do_op(tw[0], 1'b1, 8'h80, 16'h0000);
      do_op(tw[0], 1'b1, 8'h81, 16'h0000);
    end
    for (int i = 0; i < 16; i++) begin
      if ($urandom() % 3 == 0)
        do_op(1'($urandom()), 1'b1, 8'h80 | 8'($urandom() % 2), 16'h0000);
      else
        do_op(1'($urandom()), 1'b0, wsub[$urandom() % 12], 16'($urandom()));
    end
    end_of_test();
  end
endmodule
